// >>> verification/wdt_core_tb.sv
// wdt_core_tb.sv: self-checking testbench of the watchdog top over apb
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_core_tb;

  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  typedef struct
  {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic err;
  } wdt_row_t;

  logic core_clk, reset, por, count_clock, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, sys_reset, irq, er;
  int n_errors, compares, n_sysrst, c;
  wdt_row_t rows [0:12];

  wdt_core dut
  (
    .core_clk(core_clk), .reset(reset), .por(por), .count_clock(count_clock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_reset(sys_reset), .irq(irq)
  );

  // core clock 20 ns; count clock 160 ns, edges land on core falling edges, between rising ones
  always #10 core_clk = ~core_clk;
  always #80 count_clock = ~count_clock;

  // chip reset requests are counted so interrupt mode can prove it never resets
  always @(posedge core_clk)
    if (sys_reset === 1'b1)
      n_sysrst <= n_sysrst + 1;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic stop_test;
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic check_rng(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check_rng

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      $display("Error pready expected 1 seen timeout");
      stop_test();
    end
  endtask : apb

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr32

  // bounded wait for irq (sel 0) or sys_reset (sel 1); cyc equals lim if never seen
  task automatic wait_for(input int sel, input int lim, output int cyc);
    cyc = 0;
    while (cyc < lim && ((sel == 0) ? irq : sys_reset) !== 1'b1)
    begin
      @(posedge core_clk);
      cyc++;
    end
  endtask : wait_for

  task automatic feed_ok;
    wr32(`WDT_OFS_FEED, 32'hAA);
    wr32(`WDT_OFS_FEED, 32'h55);
  endtask : feed_ok

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    count_clock = 1'b0;
    reset = 1'b1;
    por = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    n_errors = 0;
    compares = 0;
    n_sysrst = 0;
    rows = '{
      '{1'b0, `WDT_OFS_MODE, 32'h0, 32'h0, 1'b0},
      '{1'b0, `WDT_OFS_RELOAD, 32'h0, 32'hFFFFFF, 1'b0},
      '{1'b0, `WDT_OFS_READBACK, 32'h0, 32'hFFFFFF, 1'b0},
      '{1'b0, `WDT_OFS_INT_STATUS, 32'h0, 32'h0, 1'b0},
      '{1'b0, `WDT_OFS_INT_MASK, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h1C, 32'h5, 32'h0, 1'b1},
      '{1'b1, `WDT_OFS_RELOAD, 32'h10, 32'h0, 1'b0},
      '{1'b0, `WDT_OFS_RELOAD, 32'h0, 32'h10, 1'b0},
      '{1'b1, `WDT_OFS_INT_MASK, 32'h3, 32'h0, 1'b0},
      '{1'b0, `WDT_OFS_INT_MASK, 32'h0, 32'h3, 1'b0},
      '{1'b1, `WDT_OFS_INT_MASK, 32'h1, 32'h0, 1'b0},
      '{1'b1, `WDT_OFS_MODE, 32'h8, 32'h0, 1'b0}
    };
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    por <= 1'b0;
    // register table: reset values, access kinds, unmapped places
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, rd, er);
      check("slverr", {31'h0, rows[i].err}, {31'h0, er});
      if (!rows[i].wr)
        check("rdata", rows[i].exp, rd);
    end
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("mode_readonly_bits", 32'h0, rd);
    // interrupt mode, reload below the floor; let settings cross first
    repeat (40) @(posedge core_clk);
    wr32(`WDT_OFS_MODE, 32'h1);
    wait_for(0, 9000, c);
    check_rng("idle_before_feed", 9000, 9000, c);
    apb(1'b0, `WDT_OFS_READBACK, 32'h0, rd, er);
    check("readback_idle", 32'hFFFFFF, rd);
    wr32(`WDT_OFS_MODE, 32'h0);
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("enable_sticky", 32'h1, rd);
    feed_ok();
    repeat (100) @(posedge core_clk);
    apb(1'b0, `WDT_OFS_READBACK, 32'h0, rd, er);
    check_rng("readback", 32'hF0, 32'hFF, int'(rd));
    // periodic feeds keep the counter from running out
    repeat (2)
    begin
      wait_for(0, 5000, c);
      check_rng("fed_no_irq", 5000, 5000, c);
      feed_ok();
    end
    // floor load 0xFF: (255+1)*4 ticks of 8 core cycles each
    wait_for(0, 9000, c);
    check_rng("underflow_time", 8184, 8230, c);
    check("no_chip_reset", 32'h0, n_sysrst);
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("mode_after_underflow", 32'hC, rd);
    apb(1'b0, `WDT_OFS_INT_STATUS, 32'h0, rd, er);
    check("status_underflow", 32'h1, rd);
    wr32(`WDT_OFS_INT_STATUS, 32'h1);
    repeat (3) @(posedge core_clk);
    check("irq_cleared", 32'h0, {31'h0, irq});
    // reset mode, broken feed pair
    wr32(`WDT_OFS_MODE, 32'h2);
    repeat (40) @(posedge core_clk);
    wr32(`WDT_OFS_MODE, 32'h3);
    wr32(`WDT_OFS_FEED, 32'hAA);
    wr32(`WDT_OFS_FEED, 32'h12);
    wait_for(1, 20, c);
    check_rng("fault_reset", 0, 19, c);
    repeat (4) @(posedge core_clk);
    check("reset_pulses", 32'h1, n_sysrst);
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("mode_after_fault", 32'h6, rd);
    apb(1'b0, `WDT_OFS_INT_STATUS, 32'h0, rd, er);
    check("status_fault", 32'h2, rd);
    wr32(`WDT_OFS_INT_MASK, 32'h3);
    repeat (3) @(posedge core_clk);
    check("irq_fault", 32'h1, {31'h0, irq});
    // a lone second byte while enabled is a fault too
    wr32(`WDT_OFS_MODE, 32'h3);
    wr32(`WDT_OFS_FEED, 32'h55);
    wait_for(1, 20, c);
    check_rng("lone_second", 0, 19, c);
    // the timeout flag outlives an ordinary reset; of the two resets only power-on clears it
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("flag_kept", 32'h4, rd);
    reset <= 1'b1;
    por <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    por <= 1'b0;
    apb(1'b0, `WDT_OFS_MODE, 32'h0, rd, er);
    check("flag_por", 32'h0, rd);
    stop_test();
  end

endmodule : wdt_core_tb

`default_nettype wire

// >>> verilog/wdt_apb_slave.sv
// wdt_apb_slave.sv: apb slave front end of the watchdog registers
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_apb_slave
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  wdt_bus_if.slave bus
);

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  wire access = psel & penable;
  wire answer_nxt = access & ~pready_r;

  // ************************************************************
  // access decode: write lands on the edge that samples pready
  // ************************************************************
  assign bus.addr = paddr[`WDT_ADDR_W-1:0];
  assign bus.wdata = pwdata;
  assign bus.wr = access & pready_r & pwrite & bus.hit;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= answer_nxt;
      pslverr_r <= answer_nxt & ~bus.hit;
      prdata_r <= (answer_nxt & ~pwrite) ? bus.rdata : 32'h00000000;
    end
  end

  a_pready_one: assert property (@(posedge core_clk) disable iff (reset)
    pready_r |=> !pready_r)
    else $error("pready stood for more than one cycle");
  a_err_unmapped: assert property (@(posedge core_clk) disable iff (reset)
    (access && !pready_r && !bus.hit) |=> pslverr_r && pready_r)
    else $error("unmapped access was not answered with an error");

endmodule : wdt_apb_slave

`default_nettype wire

// >>> verilog/wdt_bus_if.sv
// wdt_bus_if.sv: internal register access channel between bus slave and watchdog core
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

interface wdt_bus_if;
  logic wr;
  logic [`WDT_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;

  modport slave (output wr, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input addr, input wdata, output rdata, output hit);
endinterface : wdt_bus_if

`default_nettype wire

// >>> verilog/wdt_core.sv
// wdt_core.sv: watchdog top with prescaler, down-counter, feed checker and registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_core
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic por,
  input wire logic count_clock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sys_reset,
  output logic irq
);

  wdt_bus_if bus ();

  wdt_apb_slave u_apb
  (
    .core_clk (core_clk),
    .reset (reset),
    .psel (psel),
    .penable (penable),
    .pwrite (pwrite),
    .paddr (paddr),
    .pwdata (pwdata),
    .prdata (prdata),
    .pready (pready),
    .pslverr (pslverr),
    .bus (bus)
  );

  // ************************************************************
  // state
  // ************************************************************
  wdt_pkg::wdt_state_t state_r;
  wdt_pkg::wdt_state_t state_nxt;
  logic cs1_r;
  logic cs2_r;
  logic cs3_r;
  logic clk_lvl_r;
  logic [1:0] pre_r;
  logic [`WDT_CNT_W-1:0] cnt_r;
  logic [`WDT_CNT_W-1:0] reload_r;
  logic [`WDT_CNT_W-1:0] reload_cd_r;
  logic rst_mode_r;
  logic rst_mode_cd_r;
  logic en_r;
  logic tof_r;
  logic aa_seen_r;
  logic fault_r;
  logic [1:0] xfer_r;
  logic [`WDT_CNT_W-1:0] snap_r;
  logic [`WDT_CNT_W-1:0] readback_r;
  logic [`WDT_INT_W-1:0] int_status_r;
  logic [`WDT_INT_W-1:0] int_mask_r;
  logic irq_r;
  logic sys_reset_r;
  // ************************************************************
  // register decode
  // ************************************************************
  wire hit_mode = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_MODE);
  wire hit_reload = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_RELOAD);
  wire hit_feed = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_FEED);
  wire hit_rb = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_READBACK);
  wire hit_ists = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_INT_STATUS);
  wire hit_imask = wdt_pkg::wdt_hit(bus.addr, `WDT_OFS_INT_MASK);
  wire wr_mode = bus.wr & hit_mode;
  wire wr_reload = bus.wr & hit_reload;
  wire wr_feed = bus.wr & hit_feed;
  wire wr_ists = bus.wr & hit_ists;
  wire wr_imask = bus.wr & hit_imask;
  wire [7:0] feed_byte = bus.wdata[7:0];
  wire [`WDT_MODE_W-1:0] mode_view = {int_status_r[`WDT_INT_UNDERFLOW], tof_r, rst_mode_r, en_r};

  // read mux; unlisted bits read as zero
  assign bus.hit = hit_mode | hit_reload | hit_feed | hit_rb | hit_ists | hit_imask;
  assign bus.rdata = hit_mode ? {28'h0000000, mode_view} :
                     hit_reload ? {8'h00, reload_r} :
                     hit_rb ? {8'h00, readback_r} :
                     hit_ists ? {30'h0, int_status_r} :
                     hit_imask ? {30'h0, int_mask_r} : 32'h00000000;
  // ************************************************************
  // count clock: three stages, a rising change counts when stages two and three agree
  // ************************************************************
  wire clk_stable = (cs2_r == cs3_r);
  wire tick = clk_stable & cs3_r & ~clk_lvl_r;

  // first stage feeds the second only, keeping metastability contained
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cs1_r <= 1'b0;
      cs2_r <= 1'b0;
      cs3_r <= 1'b0;
      clk_lvl_r <= 1'b0;
    end
    else
    begin
      cs1_r <= count_clock;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      clk_lvl_r <= clk_stable ? cs3_r : clk_lvl_r;
    end
  end
  // ************************************************************
  // feed checker
  // ************************************************************
  wire valid_feed = wr_feed & (feed_byte == `WDT_FEED_SECOND) & aa_seen_r;
  wire feed_first = wr_feed & (feed_byte == `WDT_FEED_FIRST);
  // a stray byte, or another register written mid-pair, breaks the pair
  wire bad_feed = en_r & ((wr_feed & ~feed_first & ~valid_feed) | (aa_seen_r & bus.wr & ~hit_feed));

  // half-pair memory; only the full pair counts
  always_ff @(posedge core_clk)
  begin
    if (reset)
      aa_seen_r <= 1'b0;
    else
      aa_seen_r <= feed_first | (aa_seen_r & ~bus.wr);
  end
  // ************************************************************
  // state machine
  // ************************************************************
  wire running = (state_r == wdt_pkg::WDT_RUN);
  wire dec = running & tick & (pre_r == `WDT_PRESCALE_LAST);
  wire underflow = dec & (cnt_r == `WDT_CNT_W'(0));

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      wdt_pkg::WDT_IDLE: if (en_r) state_nxt = wdt_pkg::WDT_ARMED;
      wdt_pkg::WDT_ARMED:
      begin
        if (bad_feed) state_nxt = wdt_pkg::WDT_FIRE;
        else if (valid_feed) state_nxt = wdt_pkg::WDT_RUN;
      end
      wdt_pkg::WDT_RUN: if (bad_feed | underflow) state_nxt = wdt_pkg::WDT_FIRE;
      wdt_pkg::WDT_FIRE: state_nxt = wdt_pkg::WDT_IDLE;
    endcase
  end

  // one cycle in fire, then back to idle with enable dropped
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r <= wdt_pkg::WDT_IDLE;
      fault_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      fault_r <= bad_feed;
    end
  end
  // ************************************************************
  // prescaler and down-counter
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pre_r <= 2'h0;
      cnt_r <= `WDT_RELOAD_RESET;
    end
    else if (valid_feed & en_r)
    begin
      pre_r <= 2'h0;
      cnt_r <= wdt_pkg::wdt_load(reload_cd_r);
    end
    else
    begin
      pre_r <= (running & tick) ? pre_r + 2'h1 : pre_r;
      cnt_r <= dec ? cnt_r - `WDT_CNT_W'(1) : cnt_r;
    end
  end
  // ************************************************************
  // software registers
  // ************************************************************
  wire fire = (state_r == wdt_pkg::WDT_FIRE);

  // enable is set-only for software; only fire or reset drops it
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      en_r <= `WDT_MODE_RESET == 4'h0 ? 1'b0 : 1'b1;
      rst_mode_r <= 1'b0;
      reload_r <= `WDT_RELOAD_RESET;
      int_mask_r <= 2'h0;
    end
    else
    begin
      en_r <= ~fire & (en_r | (wr_mode & bus.wdata[`WDT_MODE_EN]));
      rst_mode_r <= wr_mode ? bus.wdata[`WDT_MODE_RST] : rst_mode_r;
      reload_r <= wr_reload ? bus.wdata[`WDT_CNT_W-1:0] : reload_r;
      int_mask_r <= wr_imask ? bus.wdata[`WDT_INT_W-1:0] : int_mask_r;
    end
  end

  // timeout flag: power-on or a mode write with its bit at zero clears it, so it outlives the reset it caused
  always_ff @(posedge core_clk)
  begin
    if (por)
      tof_r <= 1'b0;
    else
      tof_r <= fire | (tof_r & ~(wr_mode & ~bus.wdata[`WDT_MODE_TOF]));
  end
  // ************************************************************
  // mode and reload reach the counting side three ticks later
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      xfer_r <= 2'h0;
      rst_mode_cd_r <= 1'b0;
      reload_cd_r <= `WDT_RELOAD_RESET;
    end
    else
    begin
      if (wr_mode | wr_reload)
        xfer_r <= `WDT_XFER_TICKS;
      else if (tick & (xfer_r != 2'h0))
        xfer_r <= xfer_r - 2'h1;
      if (tick & (xfer_r == 2'h1))
      begin
        rst_mode_cd_r <= rst_mode_r;
        reload_cd_r <= reload_r;
      end
    end
  end
  // ************************************************************
  // readback: lock on a tick, then hand over to the bus side
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      snap_r <= `WDT_RELOAD_RESET;
      readback_r <= `WDT_RELOAD_RESET;
    end
    else
    begin
      snap_r <= tick ? cnt_r : snap_r;
      readback_r <= snap_r;
    end
  end
  // ************************************************************
  // events, interrupt and chip reset
  // ************************************************************
  wire ev_under = fire & ~fault_r & ~rst_mode_cd_r;
  wire [`WDT_INT_W-1:0] ev = {bad_feed, ev_under};

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      int_status_r <= 2'h0;
      irq_r <= 1'b0;
      sys_reset_r <= 1'b0;
    end
    else
    begin
      int_status_r <= ev | (int_status_r & ~(wr_ists ? bus.wdata[`WDT_INT_W-1:0] : 2'h0));
      irq_r <= |(int_status_r & int_mask_r);
      sys_reset_r <= fire & rst_mode_cd_r;
    end
  end
  assign irq = irq_r;
  assign sys_reset = sys_reset_r;
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_prescale_four: assert property ((running && tick && !valid_feed) |=> pre_r == $past(pre_r) + 2'h1)
    else $error("prescaler did not step once per count tick");
  a_load_floor: assert property ((valid_feed && en_r && reload_cd_r < 24'h0000FF) |=> cnt_r == 24'h0000FF)
    else $error("short reload not raised to the floor");
  a_lone_second: assert property ((wr_feed && feed_byte == 8'h55 && !aa_seen_r && en_r) |=> fault_r)
    else $error("unpaired second byte not treated as fault");
  a_enable_sticky: assert property ((en_r && !fire) |=> en_r)
    else $error("enable dropped without a watchdog event");
  a_fault_fires: assert property ((bad_feed && state_r != wdt_pkg::WDT_IDLE) |=> fire)
    else $error("feed fault did not fire the watchdog");
  a_reset_pulse: assert property ((fire && rst_mode_cd_r) |=> sys_reset_r ##1 !sys_reset_r)
    else $error("reset mode underflow gave no one-cycle chip reset");
  a_tof_set: assert property (fire |=> tof_r)
    else $error("timeout flag not set on fire");
  a_mode_delay: assert property ((wr_mode && !wr_reload) |=> (rst_mode_cd_r == $past(rst_mode_cd_r)) [*2])
    else $error("mode reached counting side too early");
  a_feed_reload: assert property ((valid_feed && en_r) |=> cnt_r == wdt_pkg::wdt_load($past(reload_cd_r)))
    else $error("valid feed did not reload the counter");
  a_int_mode: assert property ((underflow && !rst_mode_cd_r) |=> ##1 int_status_r[0] && !sys_reset_r)
    else $error("interrupt mode underflow gave no interrupt");
  a_no_early_count: assert property ((state_r == wdt_pkg::WDT_ARMED && !valid_feed) |=> cnt_r == $past(cnt_r))
    else $error("counting began before the first feed");
  c_feed_run: cover property (valid_feed ##1 running);
  c_underflow: cover property (underflow);
  c_chip_reset: cover property (sys_reset_r);
  c_fault_irq: cover property (fault_r ##[1:3] irq_r);

endmodule : wdt_core

`default_nettype wire

// >>> verilog/wdt_defs.svh
// wdt_defs.svh: register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ************************************************************
// register map (byte addresses on the peripheral bus)
// ************************************************************
`define WDT_ADDR_W 8
`define WDT_OFS_MODE 8'h00
`define WDT_OFS_RELOAD 8'h04
`define WDT_OFS_FEED 8'h08
`define WDT_OFS_READBACK 8'h0C
`define WDT_OFS_INT_STATUS 8'h10
`define WDT_OFS_INT_MASK 8'h14

// ************************************************************
// fields of the operating-mode register
// ************************************************************
`define WDT_MODE_EN 0
`define WDT_MODE_RST 1
`define WDT_MODE_TOF 2
`define WDT_MODE_INTF 3
`define WDT_MODE_W 4
`define WDT_MODE_RESET 4'h0

// ************************************************************
// interrupt status and mask fields
// ************************************************************
`define WDT_INT_UNDERFLOW 0
`define WDT_INT_FEED_FAULT 1
`define WDT_INT_W 2

// ************************************************************
// counter, feed codes and timing
// ************************************************************
`define WDT_CNT_W 24
`define WDT_RELOAD_RESET 24'hFFFFFF
`define WDT_MIN_LOAD 24'h0000FF
`define WDT_FEED_FIRST 8'hAA
`define WDT_FEED_SECOND 8'h55
`define WDT_PRESCALE_LAST 2'h3
`define WDT_XFER_TICKS 2'h3

`endif

// >>> verilog/wdt_pkg.sv
// wdt_pkg.sv: types and shared functions of the watchdog
`include "wdt_defs.svh"

package wdt_pkg;

  // watchdog state, gray coded along idle -> armed -> run -> fire
  typedef enum logic [1:0]
  {
    WDT_IDLE = 2'b00,
    WDT_ARMED = 2'b01,
    WDT_RUN = 2'b11,
    WDT_FIRE = 2'b10
  } wdt_state_t;

  // address match against one register offset
  function automatic logic wdt_hit(input logic [`WDT_ADDR_W-1:0] addr, input logic [`WDT_ADDR_W-1:0] ofs);
    wdt_hit = (addr == ofs);
  endfunction : wdt_hit

  // counter start value, never below the floor
  function automatic logic [`WDT_CNT_W-1:0] wdt_load(input logic [`WDT_CNT_W-1:0] rel);
    wdt_load = (rel < `WDT_MIN_LOAD) ? `WDT_MIN_LOAD : rel;
  endfunction : wdt_load

endpackage : wdt_pkg
